/* rtl/flash_self_program_control.sv */
// Operation
// - unlock key port stores nothing, reads zero
// - single word programs two, else 64 bytes
// - erase select erases; cleared on erase completion
// - write permit gates cycles; clear at reset
// - error flag set on start, cleared on completion
// - error flag survives reset and improper attempts
// - start bit software-settable only, hardware cleared
// - control bits 7, 6, 0 read zero
// - space selects untouched on error
// - table latch holds each moved byte
// - three pointer bytes form 22-bit address
// - auto updates touch only low 21 bits
// - table read uses all 22 bits
// - table write fills holding register by pointer
// - pointer bits 21:6 choose programmed block
// - erase clears block, ignoring bits 9:0
// - four pointer update modes per table op
// - table read moves exactly one byte
// - pointer bit zero picks word byte
// - erase only whole 512-word blocks
// - core stalls during long write or erase
// - holding registers keep contents after programming
`default_nettype none
module flash_self_program_control
    import flash_ctrl_pkg::*;
#(
    parameter int TIMER_CYCLES = 64,
    parameter int ARRAY_WORD_W = 16
) (
    input wire logic clock_i,
    input wire logic sys_rst_i,
    input wire logic clk_en_i,
    input wire reg_req_t reg_req_i,
    output logic [7:0] reg_rdata_o,
    input wire table_req_t table_req_i,
    input wire logic memory_space_select_i,
    input wire logic config_space_select_i,
    output logic core_stall_o,
    output logic [PTR_W-1:0] array_addr_o,
    input wire logic [ARRAY_WORD_W-1:0] array_rdata_i,
    output logic array_erase_o,
    output logic array_prog_o,
    output logic [7:0] array_prog_data_o,
    output logic array_busy_o,
    output logic memory_space_select_o,
    output logic config_space_select_o
);
    initial begin
        if (TIMER_CYCLES < 1 || ARRAY_WORD_W != 16) begin
            $error("unsupported timer or array word width");
        end
    end

    typedef enum logic [3:0] {
        ST_IDLE = 4'b0001,
        ST_ERASE = 4'b0010,
        ST_PROG = 4'b0100,
        ST_WAIT = 4'b1000
    } op_state_t;

    typedef enum logic [2:0] {
        KEY_NONE = 3'b001,
        KEY_GOT_FIRST = 3'b010,
        KEY_ARMED = 3'b100
    } key_state_t;

    op_state_t state_reg;
    key_state_t key_reg;
    logic single_word_reg;
    logic erase_sel_reg;
    logic error_reg;
    logic permit_reg;
    logic start_reg;
    logic [7:0] latch_reg;
    logic [PTR_W-1:0] ptr_reg;
    logic [PTR_W-1:0] ptr_next;
    logic [PTR_W-1:0] op_base_reg;
    logic [HOLD_IDX_W-1:0] byte_cnt_reg;
    logic [HOLD_IDX_W-1:0] last_idx_reg;
    logic [15:0] timer_reg;
    logic [7:0] hold_rdata;
    logic space_mem_reg;
    logic space_cfg_reg;
    logic [PTR_W-1:0] read_addr;

    logic wr_ctl;
    logic wr_key;
    logic start_req;
    logic start_ok;
    logic busy;
    logic [7:0] ctl_view;
    logic [PTR_W-1:0] ptr_pre;

    assign busy = (state_reg != ST_IDLE);
    assign wr_ctl = reg_req_i.wr_en && reg_req_i.sel == SEL_CONTROL;
    assign wr_key = reg_req_i.wr_en && reg_req_i.sel == SEL_KEY;
    assign start_req = wr_ctl && reg_req_i.wdata[CTL_START] && !start_reg;
    // start honoured only right after unlock and with permit set
    // permit comes from the start write itself, so one write may do both
    assign start_ok = start_req && key_reg == KEY_ARMED
        && reg_req_i.wdata[CTL_PERMIT]
        && state_reg == ST_IDLE;

    // unlock key: a sequence tracker, no storage
    always_ff @(posedge clock_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            key_reg <= KEY_NONE;
        end else if (clk_en_i) begin
            if (wr_key) begin
                case (key_reg)
                    KEY_NONE:
                        key_reg <= (reg_req_i.wdata == KEY_FIRST)
                            ? KEY_GOT_FIRST : KEY_NONE;
                    KEY_GOT_FIRST:
                        key_reg <= (reg_req_i.wdata == KEY_SECOND)
                            ? KEY_ARMED : KEY_NONE;
                    default:
                        key_reg <= (reg_req_i.wdata == KEY_FIRST)
                            ? KEY_GOT_FIRST : KEY_NONE;
                endcase
            end else if (reg_req_i.wr_en || reg_req_i.rd_en) begin
                // any other access breaks the sequence
                key_reg <= KEY_NONE;
            end
        end
    end

    // control bits software owns
    always_ff @(posedge clock_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            single_word_reg <= CTL_RESET[CTL_SINGLE_WORD];
            permit_reg <= CTL_RESET[CTL_PERMIT];
        end else if (clk_en_i && wr_ctl) begin
            single_word_reg <= reg_req_i.wdata[CTL_SINGLE_WORD];
            permit_reg <= reg_req_i.wdata[CTL_PERMIT];
        end
    end

    // erase select: software writes, hardware clears on erase done
    always_ff @(posedge clock_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            erase_sel_reg <= CTL_RESET[CTL_ERASE_SEL];
        end else if (clk_en_i) begin
            if (state_reg == ST_ERASE && timer_reg == 16'h0000) begin
                erase_sel_reg <= 1'b0;
            end else if (wr_ctl && !busy) begin
                erase_sel_reg <= reg_req_i.wdata[CTL_ERASE_SEL];
            end
        end
    end

    // start bit: set only, cleared by hardware at completion
    always_ff @(posedge clock_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            start_reg <= 1'b0;
        end else if (clk_en_i) begin
            if (state_reg == ST_WAIT) begin
                start_reg <= 1'b0;
            end else if (start_ok) begin
                start_reg <= 1'b1;
            end
        end
    end

    // error flag has no reset: an interrupted cycle leaves it set
    always_ff @(posedge clock_i) begin
        if (clk_en_i) begin
            if (start_ok || (start_req && !start_ok)) begin
                error_reg <= 1'b1;
            end else if (state_reg == ST_WAIT) begin
                error_reg <= 1'b0;
            end else if (wr_ctl && !reg_req_i.wdata[CTL_ERROR]) begin
                error_reg <= 1'b0;
            end
        end
    end

    // space selects captured at start, never cleared by an error
    always_ff @(posedge clock_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            space_mem_reg <= 1'b0;
            space_cfg_reg <= 1'b0;
        end else if (clk_en_i && !busy) begin
            space_mem_reg <= memory_space_select_i;
            space_cfg_reg <= config_space_select_i;
        end
    end
    assign memory_space_select_o = space_mem_reg;
    assign config_space_select_o = space_cfg_reg;

    // table pointer update, low 21 bits only
    always_comb begin
        ptr_pre = ptr_reg;
        ptr_next = ptr_reg;
        if (table_req_i.mode == PTR_PRE_INC) begin
            ptr_pre = {ptr_reg[PTR_W-1],
                ptr_reg[LOW_PTR_W-1:0] + 21'h00_0001};
        end
        case (table_req_i.mode)
            PTR_KEEP: ptr_next = ptr_reg;
            PTR_POST_INC: ptr_next = {ptr_reg[PTR_W-1],
                ptr_reg[LOW_PTR_W-1:0] + 21'h00_0001};
            PTR_POST_DEC: ptr_next = {ptr_reg[PTR_W-1],
                ptr_reg[LOW_PTR_W-1:0] - 21'h00_0001};
            PTR_PRE_INC: ptr_next = ptr_pre;
            default: ptr_next = ptr_reg;
        endcase
    end

    logic table_op;
    assign table_op = (table_req_i.rd_en || table_req_i.wr_en) && !busy;

    always_ff @(posedge clock_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            ptr_reg <= '0;
        end else if (clk_en_i) begin
            if (table_op) begin
                ptr_reg <= ptr_next;
            end else if (reg_req_i.wr_en && !busy) begin
                case (reg_req_i.sel)
                    SEL_PTR_UP: ptr_reg[PTR_W-1:16] <=
                        reg_req_i.wdata[PTR_W-17:0];
                    SEL_PTR_HI: ptr_reg[15:8] <= reg_req_i.wdata;
                    SEL_PTR_LO: ptr_reg[7:0] <= reg_req_i.wdata;
                    default: ptr_reg <= ptr_reg;
                endcase
            end
        end
    end

    // array read word; bit zero picks the byte
    assign read_addr = ptr_pre;

    always_ff @(posedge clock_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            latch_reg <= 8'h00;
        end else if (clk_en_i) begin
            if (table_req_i.rd_en && !busy) begin
                latch_reg <= read_addr[0] ? array_rdata_i[15:8]
                    : array_rdata_i[7:0];
            end else if (reg_req_i.wr_en && reg_req_i.sel == SEL_LATCH) begin
                latch_reg <= reg_req_i.wdata;
            end
        end
    end

    // holding registers written by table writes only
    flash_hold_buffer #(
        .DEPTH(HOLD_DEPTH),
        .IDX_W(HOLD_IDX_W)
    ) u_hold (
        .clock_i(clock_i),
        .clk_en_i(clk_en_i),
        .wr_i(table_req_i.wr_en && !busy),
        .wr_idx_i(ptr_pre[HOLD_IDX_W-1:0]),
        .wr_data_i(latch_reg),
        .rd_idx_i(byte_cnt_reg),
        .rd_data_o(hold_rdata)
    );

    // long write / erase sequencer
    always_ff @(posedge clock_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            state_reg <= ST_IDLE;
            op_base_reg <= '0;
            byte_cnt_reg <= '0;
            last_idx_reg <= '0;
            timer_reg <= 16'h0000;
        end else if (clk_en_i) begin
            case (state_reg)
                ST_IDLE: begin
                    if (start_ok) begin
                        // block base ignores bits 9:0
                        op_base_reg <= {ptr_reg[PTR_W-1:BLOCK_LSB],
                            {BLOCK_LSB{1'b0}}};
                        timer_reg <= 16'(TIMER_CYCLES - 1);
                        // mode bits of the starting write take effect now
                        if (reg_req_i.wdata[CTL_ERASE_SEL]) begin
                            state_reg <= ST_ERASE;
                        end else if (reg_req_i.wdata[CTL_SINGLE_WORD]) begin
                            byte_cnt_reg <= {ptr_reg[HOLD_IDX_W-1:1], 1'b0};
                            last_idx_reg <= {ptr_reg[HOLD_IDX_W-1:1],
                                1'b1};
                            state_reg <= ST_PROG;
                        end else begin
                            byte_cnt_reg <= '0;
                            last_idx_reg <=
                                6'(BLOCK_PROG_BYTES - 1);
                            state_reg <= ST_PROG;
                        end
                    end
                end
                ST_ERASE: begin
                    if (timer_reg == 16'h0000) begin
                        state_reg <= ST_WAIT;
                    end else begin
                        timer_reg <= timer_reg - 16'h0001;
                    end
                end
                ST_PROG: begin
                    if (byte_cnt_reg != last_idx_reg) begin
                        byte_cnt_reg <= byte_cnt_reg + 6'h01;
                    end
                    if (timer_reg != 16'h0000) begin
                        timer_reg <= timer_reg - 16'h0001;
                    end
                    if (byte_cnt_reg == last_idx_reg
                        && timer_reg == 16'h0000) begin
                        state_reg <= ST_WAIT;
                    end
                end
                ST_WAIT: state_reg <= ST_IDLE;
                default: state_reg <= ST_IDLE;
            endcase
        end
    end

    // erase pulses whole block once; program strobes one byte a cycle
    assign array_erase_o = (state_reg == ST_ERASE)
        && timer_reg == 16'(TIMER_CYCLES - 1);
    // the timer may outlast the bytes: strobe each byte only once
    logic prog_done_reg;
    always_ff @(posedge clock_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            prog_done_reg <= 1'b0;
        end else if (clk_en_i) begin
            prog_done_reg <= state_reg == ST_PROG
                && (prog_done_reg || byte_cnt_reg == last_idx_reg);
        end
    end
    assign array_prog_o = (state_reg == ST_PROG)
        && !prog_done_reg;
    assign array_prog_data_o = hold_rdata;
    assign array_addr_o = busy
        ? {op_base_reg[PTR_W-1:BLOCK_LSB],
           ptr_reg[BLOCK_LSB-1:HOLD_IDX_W], byte_cnt_reg}
        : read_addr;
    assign array_busy_o = busy;
    assign core_stall_o = busy;

    // register read side
    assign ctl_view = {2'b00, single_word_reg, erase_sel_reg, error_reg,
        permit_reg, start_reg, 1'b0} & CTL_MASK;
    always_comb begin
        case (reg_req_i.sel)
            SEL_CONTROL: reg_rdata_o = ctl_view;
            SEL_KEY: reg_rdata_o = 8'h00;
            SEL_LATCH: reg_rdata_o = latch_reg;
            SEL_PTR_UP: reg_rdata_o = {2'b00, ptr_reg[PTR_W-1:16]};
            SEL_PTR_HI: reg_rdata_o = ptr_reg[15:8];
            SEL_PTR_LO: reg_rdata_o = ptr_reg[7:0];
            default: reg_rdata_o = 8'h00;
        endcase
    end
endmodule // flash_self_program_control
`default_nettype wire

/* rtl/flash_ctrl_pkg.sv */
`default_nettype none
package flash_ctrl_pkg;
    localparam int PTR_W = 22;
    localparam int LOW_PTR_W = 21;
    localparam int HOLD_DEPTH = 64;
    localparam int HOLD_IDX_W = 6;
    localparam int BLOCK_LSB = 10;
    localparam int CTL_SINGLE_WORD = 5;
    localparam int CTL_ERASE_SEL = 4;
    localparam int CTL_ERROR = 3;
    localparam int CTL_PERMIT = 2;
    localparam int CTL_START = 1;
    localparam logic [7:0] CTL_RESET = 8'h00;
    localparam logic [7:0] CTL_MASK = 8'h3e;
    localparam logic [7:0] KEY_FIRST = 8'h55;
    localparam logic [7:0] KEY_SECOND = 8'hAA;
    localparam int SINGLE_WORD_BYTES = 2;
    localparam int BLOCK_PROG_BYTES = 64;
    // register select codes on the core's special function bus
    localparam logic [2:0] SEL_CONTROL = 3'h0;
    localparam logic [2:0] SEL_KEY = 3'h1;
    localparam logic [2:0] SEL_LATCH = 3'h2;
    localparam logic [2:0] SEL_PTR_UP = 3'h3;
    localparam logic [2:0] SEL_PTR_HI = 3'h4;
    localparam logic [2:0] SEL_PTR_LO = 3'h5;
    // pointer update modes carried by a table instruction
    typedef enum logic [1:0] {
        PTR_KEEP = 2'h0,
        PTR_POST_INC = 2'h1,
        PTR_POST_DEC = 2'h2,
        PTR_PRE_INC = 2'h3
    } ptr_mode_t;
    typedef struct packed {
        logic rd_en;
        logic wr_en;
        logic [2:0] sel;
        logic [7:0] wdata;
    } reg_req_t;
    typedef struct packed {
        logic rd_en;
        logic wr_en;
        ptr_mode_t mode;
    } table_req_t;
endpackage
`default_nettype wire

/* rtl/flash_hold_buffer.sv */
`default_nettype none
module flash_hold_buffer
    import flash_ctrl_pkg::*;
#(
    parameter int DEPTH = HOLD_DEPTH,
    parameter int IDX_W = HOLD_IDX_W
) (
    input wire logic clock_i,
    input wire logic clk_en_i,
    input wire logic wr_i,
    input wire logic [IDX_W-1:0] wr_idx_i,
    input wire logic [7:0] wr_data_i,
    input wire logic [IDX_W-1:0] rd_idx_i,
    output logic [7:0] rd_data_o
);
    initial begin
        if (DEPTH != (1 << IDX_W)) begin
            $error("holding depth must be two to the index width");
        end
    end

    // contents survive a completed program and reset alike
    logic [7:0] mem [DEPTH];

    always_ff @(posedge clock_i) begin
        if (clk_en_i && wr_i) begin
            mem[wr_idx_i] <= wr_data_i;
        end
    end

    assign rd_data_o = mem[rd_idx_i];
endmodule // flash_hold_buffer
`default_nettype wire

/* verif/flash_array_model.sv */
`default_nettype none
module flash_array_model
    import flash_ctrl_pkg::*;
(
    input wire logic clock_i,
    input wire logic [PTR_W-1:0] addr_i,
    input wire logic erase_i,
    input wire logic prog_i,
    input wire logic [7:0] data_i,
    output logic [15:0] rdata_o
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [7:0] mem [int];
    int gen = 0;
    // untouched bytes show an address pattern, so a wrong address shows up
    function automatic logic [7:0] byte_at(int a, int g);
        return mem.exists(a) ? mem[a] : 8'(a ^ (a >> 8) ^ 8'h5a);
    endfunction
    // gen is an argument only to wake the read path after an update
    assign rdata_o = {byte_at(int'({addr_i[21:1], 1'b1}), gen),
        byte_at(int'({addr_i[21:1], 1'b0}), gen)};
    always @(posedge clock_i) begin
        if (erase_i) begin
            for (int i = 0; i < 1024; i++) begin
                mem[int'({addr_i[21:10], 10'(i)})] = 8'hff;
            end
            gen <= gen + 1;
        end
        if (prog_i) begin
            mem[int'(addr_i)] = data_i;
            gen <= gen + 1;
        end
    end
endmodule // flash_array_model
`default_nettype wire

/* verif/flash_ctrl_props.sv */
`default_nettype none
module flash_ctrl_props
    import flash_ctrl_pkg::*;
#(
    parameter int TIMER_CYCLES = 64
) (
    input wire logic clock_i,
    input wire logic sys_rst_i,
    input wire logic clk_en_i,
    input wire reg_req_t reg_req_i,
    input wire logic [7:0] reg_rdata_o,
    input wire logic core_stall_o,
    input wire logic [PTR_W-1:0] array_addr_o,
    input wire logic array_erase_o,
    input wire logic array_prog_o,
    input wire logic array_busy_o,
    input wire logic memory_space_select_o,
    input wire logic config_space_select_o
);
    localparam int BUSY_MAX = TIMER_CYCLES + BLOCK_PROG_BYTES + 4;
    int prog_cnt;
    int busy_cnt;
    logic key_prev;
    default clocking @(posedge clock_i);
    endclocking
    default disable iff (sys_rst_i);
    always_ff @(posedge clock_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            prog_cnt <= 0;
            busy_cnt <= 0;
            key_prev <= 1'b0;
        end else begin
            prog_cnt <= !core_stall_o ? 0 : prog_cnt + int'(array_prog_o);
            busy_cnt <= core_stall_o ? busy_cnt + 1 : 0;
            key_prev <= clk_en_i && reg_req_i.wr_en
                && reg_req_i.sel == SEL_KEY;
        end
    end
    sequence s_key(logic [7:0] v);
        clk_en_i && reg_req_i.wr_en && reg_req_i.sel == SEL_KEY
            && reg_req_i.wdata == v;
    endsequence
    sequence s_start;
        clk_en_i && reg_req_i.wr_en && reg_req_i.sel == SEL_CONTROL
            && reg_req_i.wdata[CTL_START] && !core_stall_o;
    endsequence
    property p_key_zero;
        reg_req_i.sel == SEL_KEY |-> reg_rdata_o == 8'h00;
    endproperty
    a_key_zero: assert property (p_key_zero)
        else $error("key port read not zero");
    property p_unimpl;
        reg_req_i.sel == SEL_CONTROL |-> (reg_rdata_o & ~CTL_MASK) == 8'h00;
    endproperty
    a_unimpl: assert property (p_unimpl)
        else $error("control spare bits not zero");
    property p_erase_go;
        s_key(KEY_FIRST) ##1 s_key(KEY_SECOND) ##1 s_start
            ##0 (reg_req_i.wdata[CTL_ERASE_SEL] && reg_req_i.wdata[CTL_PERMIT])
            |=> array_erase_o && core_stall_o;
    endproperty
    a_erase_go: assert property (p_erase_go)
        else $error("unlocked erase did not start");
    property p_no_key;
        s_start ##0 !key_prev |=> !core_stall_o;
    endproperty
    a_no_key: assert property (p_no_key)
        else $error("start without unlock began a cycle");
    property p_permit;
        s_start ##0 (!reg_req_i.wdata[CTL_PERMIT] && !reg_rdata_o[CTL_PERMIT])
            |=> !core_stall_o;
    endproperty
    a_permit: assert property (p_permit)
        else $error("cycle began with permit clear");
    property p_busy_out;
        array_erase_o || array_prog_o |-> core_stall_o && array_busy_o;
    endproperty
    a_busy_out: assert property (p_busy_out)
        else $error("array cycle without stall");
    property p_block;
        core_stall_o && $past(core_stall_o)
            |-> $stable(array_addr_o[PTR_W-1:BLOCK_LSB]);
    endproperty
    a_block: assert property (p_block)
        else $error("block address moved while busy");
    property p_space;
        core_stall_o && $past(core_stall_o) |-> $stable(memory_space_select_o)
            && $stable(config_space_select_o);
    endproperty
    a_space: assert property (p_space)
        else $error("space selects moved while busy");
    property p_prog_max;
        prog_cnt <= BLOCK_PROG_BYTES;
    endproperty
    a_prog_max: assert property (p_prog_max)
        else $error("too many bytes programmed");
    property p_busy_max;
        busy_cnt <= BUSY_MAX;
    endproperty
    a_busy_max: assert property (p_busy_max)
        else $error("busy never ended");
endmodule // flash_ctrl_props
bind flash_self_program_control flash_ctrl_props #(
    .TIMER_CYCLES(TIMER_CYCLES)
) props_i (
    .clock_i(clock_i), .sys_rst_i(sys_rst_i), .clk_en_i(clk_en_i),
    .reg_req_i(reg_req_i), .reg_rdata_o(reg_rdata_o),
    .core_stall_o(core_stall_o), .array_addr_o(array_addr_o),
    .array_erase_o(array_erase_o), .array_prog_o(array_prog_o),
    .array_busy_o(array_busy_o),
    .memory_space_select_o(memory_space_select_o),
    .config_space_select_o(config_space_select_o)
);
`default_nettype wire

/* verif/tb_flash_self_program_control.sv */
`default_nettype none
module tb_flash_self_program_control
    import flash_ctrl_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    // clock enable stays high: freezing is not exercised here
    logic clock_i = 0, sys_rst_i = 1, clk_en_i = 1, msel = 0, csel = 0;
    reg_req_t rq = '0;
    table_req_t tq = '0;
    logic [7:0] rdata, pdata, v8;
    logic stall, erase, prog, busy, mso, cso;
    logic [PTR_W-1:0] addr;
    logic [15:0] ardata;
    logic [7:0] hold [64];
    int n_errors = 0, samples_checked = 0, seed = 32'h832a;
    int ptr, lat, nprog, p, m;
    always #12.5 clock_i = ~clock_i;
    flash_self_program_control #(.TIMER_CYCLES(4))
        flash_self_program_control_i (
        .clock_i(clock_i), .sys_rst_i(sys_rst_i), .clk_en_i(clk_en_i),
        .reg_req_i(rq), .reg_rdata_o(rdata), .table_req_i(tq),
        .memory_space_select_i(msel), .config_space_select_i(csel),
        .core_stall_o(stall), .array_addr_o(addr), .array_rdata_i(ardata),
        .array_erase_o(erase), .array_prog_o(prog),
        .array_prog_data_o(pdata), .array_busy_o(busy),
        .memory_space_select_o(mso), .config_space_select_o(cso));
    flash_array_model flash_array_model_i (.clock_i(clock_i),
        .addr_i(addr), .erase_i(erase), .prog_i(prog), .data_i(pdata),
        .rdata_o(ardata));
    task automatic tally_and_finish();
        if (n_errors == 0 && samples_checked > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    task automatic chk(string n, logic [31:0] e, logic [31:0] g);
        samples_checked++;
        if (g !== e) begin
            $display("[ERR] %s expected %h seen %h", n, e, g);
            n_errors++;
        end
    endtask
    task automatic wr(logic [2:0] s, logic [7:0] d);
        @(posedge clock_i) rq <= '{1'b0, 1'b1, s, d};
        @(posedge clock_i) rq <= '0;
    endtask
    task automatic rd(logic [2:0] s, output logic [7:0] d);
        @(posedge clock_i) rq <= '{1'b1, 1'b0, s, 8'h00};
        @(posedge clock_i);
        // read data taken at the edge that samples the request
        d = rdata;
        rq <= '0;
    endtask
    // no other register access may come between the key writes and the start write
    task automatic unlock(logic [7:0] c);
        @(posedge clock_i) rq <= '{1'b0, 1'b1, SEL_KEY, KEY_FIRST};
        @(posedge clock_i) rq <= '{1'b0, 1'b1, SEL_KEY, KEY_SECOND};
        @(posedge clock_i) rq <= '{1'b0, 1'b1, SEL_CONTROL, c};
        @(posedge clock_i) rq <= '0;
    endtask
    task automatic tbl(logic r, int md);
        @(posedge clock_i) tq <= '{r, !r, ptr_mode_t'(md)};
        @(posedge clock_i) tq <= '0;
    endtask
    task automatic wait_idle();
        nprog = 0;
        for (int i = 0; i < 400 && (stall !== 1'b0 || i < 2); i++) begin
            @(negedge clock_i);
            if (prog === 1'b1)
                nprog++;
        end
        if (stall !== 1'b0) begin
            n_errors++;
            tally_and_finish();
        end
    endtask
    function automatic int step(int a, int d);
        return (a & 32'h0020_0000) | ((a + d) & 32'h001f_ffff);
    endfunction
    task automatic set_ptr(int a);
        ptr = a;
        wr(SEL_PTR_UP, 8'(a >> 16));
        wr(SEL_PTR_HI, 8'(a >> 8));
        wr(SEL_PTR_LO, 8'(a));
    endtask
    task automatic rd_chk(int a, logic [7:0] e);
        set_ptr(a);
        tbl(1, 0);
        rd(SEL_LATCH, v8);
        chk("array byte", e, v8);
    endtask
    task automatic chk_ptr();
        logic [7:0] u, h, l;
        rd(SEL_PTR_UP, u);
        rd(SEL_PTR_HI, h);
        rd(SEL_PTR_LO, l);
        chk("pointer", ptr, {u[5:0], h, l});
    endtask
    initial begin
        repeat (12) @(posedge clock_i);
        sys_rst_i <= 1'b0;
        rd(SEL_CONTROL, v8);
        chk("control", 8'h00, v8 & 8'hf7);
        wr(SEL_KEY, KEY_FIRST);
        rd(SEL_KEY, v8);
        chk("key", 8'h00, v8);
        for (int k = 0; k < 24; k++) begin
            msel <= 1'($random(seed));
            csel <= 1'($random(seed));
            p = $random(seed) & 32'h003f_ffff;
            m = (k < 4) ? k : $random(seed) & 3;
            if (k < 4)
                p = p | 32'h001f_ffff;
            set_ptr(p);
            if (m == 3)
                ptr = step(ptr, 1);
            lat = flash_array_model_i.byte_at(ptr, 0);
            if (m == 1)
                ptr = step(ptr, 1);
            if (m == 2)
                ptr = step(ptr, -1);
            tbl(1, m);
            rd(SEL_LATCH, v8);
            chk("latch", lat, v8);
            chk_ptr();
            chk("space", {msel, csel}, {mso, cso});
        end
        set_ptr(32'h0001_2c00);
        for (int i = 0; i < 64; i++) begin
            hold[i] = 8'($random(seed));
            wr(SEL_LATCH, hold[i]);
            tbl(0, 1);
        end
        set_ptr(32'h0001_2c00);
        unlock(8'h06);
        msel <= ~msel;
        wait_idle();
        chk("bytes", 64, nprog);
        rd(SEL_CONTROL, v8);
        chk("control", 8'h04, v8);
        for (int i = 0; i < 64; i++)
            rd_chk(32'h0001_2c00 + i, hold[i]);
        set_ptr(32'h0001_2c46);
        unlock(8'h26);
        wait_idle();
        chk("bytes", 2, nprog);
        rd_chk(32'h0001_2c46, hold[6]);
        rd_chk(32'h0001_2c47, hold[7]);
        set_ptr(32'h0001_2c00 | ($random(seed) & 32'h0000_03ff));
        unlock(8'h16);
        wait_idle();
        chk("bytes", 0, nprog);
        rd(SEL_CONTROL, v8);
        chk("control", 8'h04, v8);
        rd_chk(32'h0001_2bff, flash_array_model_i.byte_at(32'h0001_2bff, 0));
        rd_chk(32'h0001_2c00, 8'hff);
        rd_chk(32'h0001_2fff, 8'hff);
        wr(SEL_CONTROL, 8'h06);
        rd(SEL_CONTROL, v8);
        chk("error", 1, {stall, v8[CTL_ERROR]});
        wr(SEL_CONTROL, 8'h00);
        unlock(8'h02);
        rd(SEL_CONTROL, v8);
        chk("error", 1, {stall, v8[CTL_ERROR]});
        unlock(8'h06);
        repeat (5) @(posedge clock_i);
        sys_rst_i <= 1'b1;
        repeat (2) @(posedge clock_i);
        sys_rst_i <= 1'b0;
        rd(SEL_CONTROL, v8);
        chk("error", 1, {stall, v8[CTL_ERROR]});
        tally_and_finish();
    end
endmodule // tb_flash_self_program_control
`default_nettype wire
